// File: core/liumc_defs.svh
// Constants for the line interface mode, host access and interrupt logic.
// Assumes inclusion by bare name from the package; the design modules use its macros without including it.
// Function
// - Strap low or floating selects hardware mode
// - Strap high selects software mode, host registers
// - Hardware mode: receive outputs valid rising recovered clock
// - Hardware mode: no interrupt, edge select, some diagnostics
// - Serial access: command/address byte, then data byte
// - Insertions come from dedicated pins only
// - Recovered clock, data, violations only on pins
// - Status bit change raises latched interrupt
// - Interrupt pulls line low, never drives high
// - Level pending clears on mask write of one, condition gone or not
// - Mask one suppresses source, zero re-enables
// - Edge select picks receive and serial output edges
// - Straps select format: bipolar, AMI, zero-substitution, disabled
// - Diagnostics from pins in hardware, register in software
// - Some functions exist only in software mode
// - Only listed event sources are maskable interrupts
// - Jitter flag latches until software reads it
`ifndef LIUMC_DEFS_SVH
`define LIUMC_DEFS_SVH

// ********
// Register byte offsets
// ********
`define LIUMC_OFF_DIAG      8'h00
`define LIUMC_OFF_STATUS    8'h04
`define LIUMC_OFF_TRANS     8'h08
`define LIUMC_OFF_MASK      8'h0c
`define LIUMC_OFF_MODE      8'h10

// ********
// Register indices (byte offset / 4)
// ********
`define LIUMC_IDX_DIAG      3'h0
`define LIUMC_IDX_STATUS    3'h1
`define LIUMC_IDX_TRANS     3'h2
`define LIUMC_IDX_MASK      3'h3
`define LIUMC_IDX_MODE      3'h4

// ********
// Event bit positions (status, transition, mask)
// ********
`define LIUMC_EV_CARRIER    0
`define LIUMC_EV_PATTERN    1
`define LIUMC_EV_NETLOOP    2
`define LIUMC_EV_AIS        3
`define LIUMC_EV_DRVFAIL    4
`define LIUMC_EV_JITTER     6
`define LIUMC_EV_LEVELS     8'h1f
`define LIUMC_EV_ALL        8'h5f

// ********
// Diagnostic control bit positions
// ********
`define LIUMC_DG_LOCAL      0
`define LIUMC_DG_ANALOG     1
`define LIUMC_DG_REMOTE     2
`define LIUMC_DG_NETLOOP    3
`define LIUMC_DG_DUAL       4
`define LIUMC_DG_ALLONES    5
`define LIUMC_DG_PATTERN    6
`define LIUMC_DG_LOOPGEN    7

// ********
// Reset values and bus answers
// ********
`define LIUMC_DIAG_RST      8'h00
`define LIUMC_MASK_RST      8'h5f
`define LIUMC_TRANS_RST     8'h00
`define LIUMC_RESP_OKAY     2'h0
`define LIUMC_RESP_SLVERR   2'h2

// ********
// Serial frame layout and pin synchroniser width
// ********
`define LIUMC_SP_CMD_BITS   4'h8
`define LIUMC_SP_RD_BIT     7
`define LIUMC_SYNC_W        19

`endif

// File: core/liumc_pkg.sv
// Types shared by the mode control design modules.
// Assumes the constants header is on the include path.
`include "liumc_defs.svh"

package liumc_pkg;

  typedef enum logic [1:0] {
    LIUMC_STRAP_LOW  = 2'h0,
    LIUMC_STRAP_HIGH = 2'h1,
    LIUMC_STRAP_OPEN = 2'h2
  } liumc_strap_t;

  typedef enum logic [3:0] {
    LIUMC_SP_IDLE = 4'h1,
    LIUMC_SP_CMD  = 4'h2,
    LIUMC_SP_DATA = 4'h4,
    LIUMC_SP_HOLD = 4'h8
  } liumc_sp_state_t;

endpackage

// File: core/liumc_serial_port.sv
// Serial host port: 16-bit frames of command/address byte then data byte.
// Assumes sclk, sdi and cs_n are asynchronous pins and sclk is far slower than aclk.
`timescale 1ns/1ps

module liumc_serial_port
  import liumc_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       sclk,
  input  wire logic       sdi,
  input  wire logic       cs_n,
  input  wire logic       enable,
  input  wire logic       edge_sel,
  input  wire logic [7:0] rd_data,
  output logic      [6:0] addr,
  output logic      [7:0] wdata,
  output logic            wr_stb,
  output logic            rd_stb,
  output logic            serial_data_out,
  output logic            serial_data_oe
);

  // ********
  // Pin synchronisers
  // ********
  logic [2:0] meta_r;
  logic [2:0] sync_r;
  logic       sclk_prev_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r      <= 3'h4;
      sync_r      <= 3'h4;
      sclk_prev_r <= 1'b0;
    end else begin
      meta_r      <= {cs_n, sdi, sclk};
      sync_r      <= meta_r;
      sclk_prev_r <= sync_r[0];
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic upd_edge;
  assign sclk_rise = sync_r[0] & ~sclk_prev_r;
  assign sclk_fall = ~sync_r[0] & sclk_prev_r;
  assign upd_edge  = edge_sel ? sclk_fall : sclk_rise;

  // ********
  // Frame sequencer
  // ********
  liumc_sp_state_t state_r;
  logic [3:0]      cnt_r;
  logic [3:0]      cnt_nxt;
  logic [7:0]      sr_r;
  logic [7:0]      out_byte_r;
  logic            rd_r;
  logic            load_r;
  logic            wr_r;

  assign cnt_nxt = cnt_r + 4'h1;
  assign rd_stb  = load_r & rd_r;
  assign wr_stb  = wr_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= LIUMC_SP_IDLE;
      cnt_r   <= 4'h0;
      sr_r    <= 8'h00;
      addr    <= 7'h00;
      wdata   <= 8'h00;
      rd_r    <= 1'b0;
      load_r  <= 1'b0;
      wr_r    <= 1'b0;
    end else begin
      load_r <= 1'b0;
      wr_r   <= 1'b0;
      if (sync_r[2] || !enable) begin
        state_r <= LIUMC_SP_IDLE;
        cnt_r   <= 4'h0;
      end else if (sclk_rise) begin
        sr_r <= {sr_r[6:0], sync_r[1]};
        case (state_r)
          LIUMC_SP_IDLE, LIUMC_SP_CMD: begin
            cnt_r   <= cnt_nxt;
            state_r <= LIUMC_SP_CMD;
            if (cnt_nxt == `LIUMC_SP_CMD_BITS) begin
              addr    <= {sr_r[5:0], sync_r[1]};
              rd_r    <= sr_r[6];
              load_r  <= 1'b1;
              state_r <= LIUMC_SP_DATA;
            end
          end
          LIUMC_SP_DATA: begin
            cnt_r <= cnt_nxt;
            if (cnt_nxt == 4'h0) begin
              wdata   <= {sr_r[6:0], sync_r[1]};
              wr_r    <= ~rd_r;
              state_r <= LIUMC_SP_HOLD;
            end
          end
          LIUMC_SP_HOLD: begin
            state_r <= LIUMC_SP_HOLD;
          end
          default: begin
            state_r <= LIUMC_SP_IDLE;
          end
        endcase
      end
    end
  end

  // ********
  // Read data shifter
  // ********
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_byte_r      <= 8'h00;
      serial_data_out <= 1'b0;
      serial_data_oe  <= 1'b0;
    end else begin
      serial_data_oe <= (state_r == LIUMC_SP_DATA) & rd_r & ~sync_r[2];
      if (rd_stb) begin
        out_byte_r <= rd_data;
        if (!edge_sel) begin
          serial_data_out <= rd_data[7];
        end
      end else if (upd_edge && state_r == LIUMC_SP_DATA) begin
        if (!edge_sel) begin
          serial_data_out <= out_byte_r[~cnt_nxt[2:0]];
        end else begin
          serial_data_out <= out_byte_r[~cnt_r[2:0]];
        end
      end
    end
  end

endmodule

// File: core/liumc_top.sv
// Mode selection, register access, receive output timing and interrupt logic.
// Assumes straps, receive pins and serial pins are asynchronous; event inputs share aclk.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps

module liumc_top
  import liumc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        interface_select_strap,
  input  wire logic        interface_select_open,
  input  wire logic        line_format_strap,
  input  wire logic        line_format_open,
  input  wire logic        output_edge_select,
  input  wire logic [7:0]  hw_diag_pins,
  input  wire logic        bipolar_violation_pin,
  input  wire logic        logic_error_insert_pin,
  input  wire logic        rclk,
  input  wire logic        rx_pos_raw,
  input  wire logic        rx_neg_raw,
  input  wire logic        rx_nrz_raw,
  input  wire logic        carrier_loss_flag,
  input  wire logic        pattern_sync_in,
  input  wire logic        network_loop_in,
  input  wire logic        ais_in,
  input  wire logic        driver_fail_flag,
  input  wire logic        jitter_limit_flag,
  input  wire logic        sclk,
  input  wire logic        sdi,
  input  wire logic        cs_n,
  output logic             serial_data_out,
  output logic             serial_data_oe,
  output logic             rx_positive_rail,
  output logic             rx_negative_rail,
  output logic             rx_nrz_data,
  output logic             rx_out_enable,
  output logic             int_n_out,
  output logic             int_n_oe,
  output logic             sw_mode,
  output logic             nrz_mode,
  output logic             zero_subst_mode,
  output logic             sw_only_enable,
  output logic             local_loop_mode,
  output logic             analog_loop_mode,
  output logic             remote_loop_mode,
  output logic             network_loop_mode,
  output logic             dual_loop_mode,
  output logic             tx_all_ones_mode,
  output logic             pattern_mode,
  output logic             loop_code_gen_mode,
  output logic             violation_insert_mode,
  output logic             logic_error_insert_req
);

  // ********
  // Functions
  // ********
  function automatic liumc_strap_t strap_decode(input logic level, input logic open);
    if (open) begin
      strap_decode = LIUMC_STRAP_OPEN;
    end else if (level) begin
      strap_decode = LIUMC_STRAP_HIGH;
    end else begin
      strap_decode = LIUMC_STRAP_LOW;
    end
  endfunction

  logic [7:0] diag_r;
  logic [7:0] status_r;
  logic [7:0] trans_r;
  logic [7:0] mask_r;
  logic [7:0] mode_word;

  function automatic logic [7:0] reg_read(input logic [2:0] idx);
    case (idx)
      `LIUMC_IDX_DIAG:   reg_read = diag_r;
      `LIUMC_IDX_STATUS: reg_read = status_r;
      `LIUMC_IDX_TRANS:  reg_read = trans_r;
      `LIUMC_IDX_MASK:   reg_read = mask_r;
      `LIUMC_IDX_MODE:   reg_read = mode_word;
      default:           reg_read = 8'h00;
    endcase
  endfunction

  function automatic logic reg_mapped(input logic [7:0] byte_addr);
    reg_mapped = (byte_addr[1:0] == 2'h0) && (byte_addr <= `LIUMC_OFF_MODE);
  endfunction

  // ********
  // Pin synchronisers
  // ********
  logic [`LIUMC_SYNC_W-1:0] pins_raw;
  logic [`LIUMC_SYNC_W-1:0] pins_s;
  assign pins_raw = {hw_diag_pins, rx_nrz_raw, rx_neg_raw, rx_pos_raw, rclk,
                     logic_error_insert_pin, bipolar_violation_pin, output_edge_select,
                     line_format_open, line_format_strap,
                     interface_select_open, interface_select_strap};

  genvar gi;
  generate
    for (gi = 0; gi < `LIUMC_SYNC_W; gi++) begin : g_sync
      logic meta_r;
      logic sync_r;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
        end else begin
          meta_r <= pins_raw[gi];
          sync_r <= meta_r;
        end
      end
      assign pins_s[gi] = sync_r;
    end
  endgenerate

  // ********
  // Mode selection
  // ********
  liumc_strap_t sel_strap;
  liumc_strap_t fmt_strap;
  logic         edge_sel_s;
  assign sel_strap  = strap_decode(pins_s[0], pins_s[1]);
  assign fmt_strap  = strap_decode(pins_s[2], pins_s[3]);
  assign edge_sel_s = pins_s[4];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_mode         <= 1'b0;
      nrz_mode        <= 1'b0;
      zero_subst_mode <= 1'b0;
      rx_out_enable   <= 1'b0;
    end else begin
      sw_mode         <= (sel_strap == LIUMC_STRAP_HIGH);
      nrz_mode        <= (sel_strap == LIUMC_STRAP_OPEN) ||
                         (sel_strap == LIUMC_STRAP_LOW && fmt_strap == LIUMC_STRAP_OPEN);
      zero_subst_mode <= (sel_strap == LIUMC_STRAP_OPEN);
      rx_out_enable   <= (fmt_strap != LIUMC_STRAP_HIGH);
    end
  end

  assign mode_word      = {4'h0, ~rx_out_enable, zero_subst_mode, nrz_mode, sw_mode};
  assign sw_only_enable = sw_mode;

  // ********
  // Diagnostic mode outputs
  // ********
  logic [7:0] diag_sel;
  assign diag_sel = sw_mode ? diag_r : {1'b0, pins_s[18:12]};

  assign local_loop_mode    = diag_sel[`LIUMC_DG_LOCAL];
  assign analog_loop_mode   = diag_sel[`LIUMC_DG_ANALOG];
  assign remote_loop_mode   = diag_sel[`LIUMC_DG_REMOTE];
  assign network_loop_mode  = diag_sel[`LIUMC_DG_NETLOOP];
  assign dual_loop_mode     = diag_sel[`LIUMC_DG_DUAL];
  assign tx_all_ones_mode   = diag_sel[`LIUMC_DG_ALLONES];
  assign pattern_mode       = diag_sel[`LIUMC_DG_PATTERN];
  assign loop_code_gen_mode = diag_sel[`LIUMC_DG_LOOPGEN];

  // Insertion triggers pass from their pins only, in both modes
  assign violation_insert_mode  = pins_s[5];
  assign logic_error_insert_req = pins_s[6];

  // ********
  // Receive output timing
  // ********
  logic rclk_prev_r;
  logic rclk_rise;
  logic rclk_fall;
  logic rx_upd;
  assign rclk_rise = pins_s[7] & ~rclk_prev_r;
  assign rclk_fall = ~pins_s[7] & rclk_prev_r;
  // Hardware mode always updates on falling edges so data is valid at rising edges
  assign rx_upd = (sw_mode && edge_sel_s) ? rclk_rise : rclk_fall;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rclk_prev_r      <= 1'b0;
      rx_positive_rail <= 1'b0;
      rx_negative_rail <= 1'b0;
      rx_nrz_data      <= 1'b0;
    end else begin
      rclk_prev_r <= pins_s[7];
      if (rx_upd) begin
        rx_positive_rail <= pins_s[8];
        rx_negative_rail <= pins_s[9];
        rx_nrz_data      <= pins_s[10];
      end
    end
  end

  // ********
  // AXI4-Lite slave
  // ********
  logic        aw_got_r;
  logic        w_got_r;
  logic [7:0]  aw_addr_r;
  logic [7:0]  w_data_r;
  logic        w_lane_r;
  logic        axi_wr;
  logic        axi_rd;

  assign s_axi_awready = ~aw_got_r;
  assign s_axi_wready  = ~w_got_r;
  assign s_axi_arready = ~s_axi_rvalid;
  assign axi_wr        = aw_got_r & w_got_r & ~s_axi_bvalid;
  assign axi_rd        = s_axi_arvalid & s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r     <= 1'b0;
      w_got_r      <= 1'b0;
      aw_addr_r    <= 8'h00;
      w_data_r     <= 8'h00;
      w_lane_r     <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `LIUMC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r  <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r  <= 1'b1;
        w_data_r <= s_axi_wdata[7:0];
        w_lane_r <= s_axi_wstrb[0];
      end
      if (axi_wr) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= reg_mapped(aw_addr_r) ? `LIUMC_RESP_OKAY : `LIUMC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `LIUMC_RESP_OKAY;
    end else if (axi_rd) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= reg_mapped(s_axi_araddr) ? {24'h00_0000, reg_read(s_axi_araddr[4:2])}
                                               : 32'h0000_0000;
      s_axi_rresp  <= reg_mapped(s_axi_araddr) ? `LIUMC_RESP_OKAY : `LIUMC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ********
  // Serial host port
  // ********
  logic [6:0] sp_addr;
  logic [7:0] sp_wdata;
  logic       sp_wr;
  logic       sp_rd;
  logic       sp_hit;
  assign sp_hit = (sp_addr <= 7'(`LIUMC_IDX_MODE));

  liumc_serial_port u_serial (
    .aclk            (aclk),
    .aresetn         (aresetn),
    .sclk            (sclk),
    .sdi             (sdi),
    .cs_n            (cs_n),
    .enable          (sw_mode),
    .edge_sel        (edge_sel_s),
    .rd_data         (sp_hit ? reg_read(sp_addr[2:0]) : 8'h00),
    .addr            (sp_addr),
    .wdata           (sp_wdata),
    .wr_stb          (sp_wr),
    .rd_stb          (sp_rd),
    .serial_data_out (serial_data_out),
    .serial_data_oe  (serial_data_oe)
  );

  // ********
  // Register writes, bus before serial port
  // ********
  logic       wr_en;
  logic [2:0] wr_idx;
  logic [7:0] wr_val;
  logic       rd_trans;
  assign wr_en    = axi_wr ? (reg_mapped(aw_addr_r) & w_lane_r) : (sp_wr & sp_hit);
  assign wr_idx   = axi_wr ? aw_addr_r[4:2] : sp_addr[2:0];
  assign wr_val   = axi_wr ? w_data_r : sp_wdata;
  assign rd_trans = (axi_rd && reg_mapped(s_axi_araddr) &&
                     s_axi_araddr[4:2] == `LIUMC_IDX_TRANS) ||
                    (sp_rd && sp_hit && sp_addr[2:0] == `LIUMC_IDX_TRANS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      diag_r <= `LIUMC_DIAG_RST;
      mask_r <= `LIUMC_MASK_RST;
    end else if (wr_en) begin
      if (wr_idx == `LIUMC_IDX_DIAG) begin
        diag_r <= wr_val;
      end
      if (wr_idx == `LIUMC_IDX_MASK) begin
        mask_r <= wr_val & `LIUMC_EV_ALL;
      end
    end
  end

  // ********
  // Status, transitions and interrupt
  // ********
  logic [7:0] status_now;
  logic [7:0] change;
  logic [7:0] clr;
  logic [7:0] trans_nxt;
  assign status_now = {3'h0, driver_fail_flag, ais_in, network_loop_in, pattern_sync_in,
                       carrier_loss_flag};
  assign change = sw_mode ? (((status_now ^ status_r) & `LIUMC_EV_LEVELS) |
                             {1'b0, jitter_limit_flag, 6'h00}) : 8'h00;
  // Mask write of one acknowledges; reading the register acknowledges the jitter flag
  assign clr = ((wr_en && wr_idx == `LIUMC_IDX_MASK) ? (wr_val & `LIUMC_EV_LEVELS) : 8'h00) |
               (rd_trans ? 8'h40 : 8'h00);
  assign trans_nxt = (trans_r & ~clr) | change;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= 8'h00;
      trans_r  <= `LIUMC_TRANS_RST;
    end else begin
      status_r <= status_now;
      trans_r  <= trans_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_n_oe <= 1'b0;
    end else begin
      int_n_oe <= sw_mode & |(trans_r & ~mask_r & `LIUMC_EV_ALL);
    end
  end

  assign int_n_out = 1'b0;

endmodule

// File: test/liumc_host_model.sv
// Host on the serial control port: 16-bit frames at a 160 ns serial clock.
// Assumes the bench starts frames through xfer; the clock rests low between frames.
`timescale 1ns/1ps
module liumc_host_model (
  output logic      sclk,
  output logic      sdi,
  output logic      cs_n,
  input  wire logic serial_data_out,
  input  wire logic edge_sel
);
  initial begin
    sclk = 1'b0;
    sdi = 1'b0;
    cs_n = 1'b1;
  end
  // Read flag and index byte, then data byte, most significant bit first
  task automatic xfer(input logic [15:0] w, output logic [7:0] rd);
    cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdi = w[i];
      #40 sclk = 1'b1;
      #40 if (!edge_sel && i < 9 && i > 0) rd = {rd[6:0], serial_data_out};
      #40 sclk = 1'b0;
      #40 if (edge_sel && i < 9 && i > 0) rd = {rd[6:0], serial_data_out};
    end
    cs_n = 1'b1;
    sdi = ~sdi; // Released line shows no stale bit
  endtask
endmodule

// File: test/liumc_mode_control_interrupt_tb.sv
// Bench for liumc_top: straps, diagnostics, interrupt, serial port, receive edges.
// Assumes the host model and checker are compiled first.
`timescale 1ns/1ps
module liu_mode_control_interrupt_tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, rclk, sclk, sdi;
  logic interface_select_strap, interface_select_open, line_format_strap, line_format_open;
  logic output_edge_select, bipolar_violation_pin, logic_error_insert_pin, cs_n, serial_data_out;
  logic rx_pos_raw, rx_neg_raw, rx_nrz_raw, carrier_loss_flag, pattern_sync_in, network_loop_in;
  logic ais_in, driver_fail_flag, jitter_limit_flag, serial_data_oe, rx_positive_rail, sw_mode;
  logic rx_negative_rail, rx_nrz_data, rx_out_enable, int_n_out, int_n_oe, nrz_mode;
  logic zero_subst_mode, sw_only_enable, local_loop_mode, analog_loop_mode, remote_loop_mode;
  logic network_loop_mode, dual_loop_mode, tx_all_ones_mode, pattern_mode, loop_code_gen_mode;
  logic violation_insert_mode, logic_error_insert_req;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, hw_diag_pins;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  int          num_errors = 0;
  int          total_checks = 0;
  wire  [7:0]  diag_out = {loop_code_gen_mode, pattern_mode, tx_all_ones_mode, dual_loop_mode,
                           network_loop_mode, remote_loop_mode, analog_loop_mode, local_loop_mode};
  wire  [2:0]  rx_out = {rx_positive_rail, rx_negative_rail, rx_nrz_data};
  liumc_top u_liumc_top (.*);
  liumc_host_model u_liumc_host_model (.sclk(sclk), .sdi(sdi), .cs_n(cs_n),
    .serial_data_out(serial_data_out), .edge_sel(output_edge_select));
  always #2 aclk = ~aclk;
  // ********
  // Shared tasks
  // ********
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    check(s_axi_bresp, 2'h0);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    check(s_axi_rdata, e);
    check(s_axi_rresp, er);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ********
  // Scenarios
  // ********
  task automatic t_straps;
    rd_chk(8'h0c, 32'h5f, 2'h0);
    for (int k = 0; k < 9; k++) begin
      @(posedge aclk);
      {interface_select_open, interface_select_strap} <= 2'(k / 3);
      {line_format_open, line_format_strap} <= 2'(k % 3);
      repeat (6) @(posedge aclk);
      check(sw_mode, k / 3 == 1);
      check(rx_out_enable, k % 3 != 1);
      if (k / 3 != 1) check({nrz_mode, zero_subst_mode}, {k > 5 || k % 3 == 2, k > 5});
    end
    $display("straps done");
  endtask
  task automatic t_diag;
    hw_diag_pins <= 8'hff;
    bipolar_violation_pin <= 1'b1;
    logic_error_insert_pin <= 1'b1;
    repeat (6) @(posedge aclk);
    check(diag_out, 8'h7f);
    check({violation_insert_mode, logic_error_insert_req}, 2'h3);
    interface_select_strap <= 1'b1;
    interface_select_open <= 1'b0;
    repeat (6) @(posedge aclk);
    axi_wr(8'h00, 32'ha5);
    check(diag_out, 8'ha5);
    rd_chk(8'h00, 32'ha5, 2'h0);
    rd_chk(8'h14, 32'h0, 2'h2);
    $display("diag done");
  endtask
  task automatic t_irq;
    axi_wr(8'h0c, 32'h0);
    carrier_loss_flag <= 1'b1;
    driver_fail_flag <= 1'b1;
    repeat (5) @(posedge aclk);
    check(int_n_oe, 1'b1);
    rd_chk(8'h08, 32'h11, 2'h0);
    axi_wr(8'h0c, 32'hff);
    repeat (3) @(posedge aclk);
    check(int_n_oe, 1'b0);
    rd_chk(8'h0c, 32'h5f, 2'h0);
    carrier_loss_flag <= 1'b0;
    repeat (5) @(posedge aclk);
    check(int_n_oe, 1'b0);
    axi_wr(8'h0c, 32'h0);
    repeat (3) @(posedge aclk);
    check(int_n_oe, 1'b1);
    axi_wr(8'h0c, 32'h1f);
    jitter_limit_flag <= 1'b1;
    @(posedge aclk);
    jitter_limit_flag <= 1'b0;
    repeat (4) @(posedge aclk);
    check(int_n_oe, 1'b1);
    rd_chk(8'h08, 32'h40, 2'h0);
    rd_chk(8'h08, 32'h00, 2'h0);
    check(int_n_oe, 1'b0);
    $display("irq done");
  endtask
  task automatic t_serial;
    logic [7:0] r;
    u_liumc_host_model.xfer(16'h003c, r);
    rd_chk(8'h00, 32'h3c, 2'h0);
    for (int es = 0; es < 2; es++) begin
      output_edge_select <= es[0];
      repeat (4) @(posedge aclk);
      u_liumc_host_model.xfer(16'h8300, r);
      check(r, 8'h1f);
      @(posedge aclk);
    end
    $display("serial done");
  endtask
  task automatic t_rx(input logic up, input logic es, input logic v);
    output_edge_select <= es;
    {rx_pos_raw, rx_neg_raw, rx_nrz_raw} <= {v, ~v, v};
    repeat (20) @(posedge aclk);
    rclk <= 1'b1;
    repeat (20) @(posedge aclk);
    check(rx_out, up ? {v, ~v, v} : {~v, v, ~v});
    rclk <= 1'b0;
    repeat (20) @(posedge aclk);
    check(rx_out, {v, ~v, v});
    $display("rx done");
  endtask
  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {interface_select_strap, interface_select_open, line_format_strap, line_format_open} = '0;
    {output_edge_select, bipolar_violation_pin, logic_error_insert_pin, rclk, rx_pos_raw} = '0;
    {rx_neg_raw, rx_nrz_raw, carrier_loss_flag, pattern_sync_in, network_loop_in, ais_in} = '0;
    {driver_fail_flag, jitter_limit_flag, s_axi_awaddr, s_axi_araddr, hw_diag_pins} = '0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_straps;
    t_diag;
    t_irq;
    t_serial;
    t_rx(1'b1, 1'b1, 1'b1);
    t_rx(1'b0, 1'b0, 1'b0);
    interface_select_strap <= 1'b0;
    t_rx(1'b0, 1'b1, 1'b1);
    finish_test;
  end
  initial begin
    #200000;
    num_errors++;
    finish_test;
  end
endmodule

// File: test/liumc_props.sv
// Checker of mode, interrupt pin and insertion pin behaviour at the liumc_top ports.
// Assumes aclk is the only clock and aresetn is synchronous, active low.
`timescale 1ns/1ps
module liumc_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic interface_select_strap,
  input wire logic interface_select_open,
  input wire logic bipolar_violation_pin,
  input wire logic violation_insert_mode,
  input wire logic int_n_out,
  input wire logic int_n_oe,
  input wire logic sw_mode,
  input wire logic sw_only_enable,
  input wire logic loop_code_gen_mode
);
  // ********
  // Properties
  // ********
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_sel_hi; (interface_select_strap && !interface_select_open) [*4]; endsequence
  sequence s_sel_lo; (!interface_select_strap || interface_select_open) [*4]; endsequence
  property p_sel_hi; s_sel_hi |=> sw_mode; endproperty
  a_sel_hi: assert property (p_sel_hi) else $error("no sw mode");
  property p_sel_lo; s_sel_lo |=> !sw_mode; endproperty
  a_sel_lo: assert property (p_sel_lo) else $error("no hw mode");
  property p_no_int; !sw_mode [*3] |-> !int_n_oe; endproperty
  a_no_int: assert property (p_no_int) else $error("irq in hw mode");
  property p_oe_sw; int_n_oe |-> $past(sw_mode); endproperty
  a_oe_sw: assert property (p_oe_sw) else $error("irq without sw mode");
  property p_int_low; int_n_out == 1'b0; endproperty
  a_int_low: assert property (p_int_low) else $error("irq drives high");
  property p_sw_only; sw_only_enable == sw_mode; endproperty
  a_sw_only: assert property (p_sw_only) else $error("sw only enable");
  property p_no_gen; !sw_mode |-> !loop_code_gen_mode; endproperty
  a_no_gen: assert property (p_no_gen) else $error("loop code gen in hw");
  property p_ins; violation_insert_mode == $past(bipolar_violation_pin, 2); endproperty
  a_ins: assert property (p_ins) else $error("insert pin");
endmodule
bind liumc_top liumc_props u_liumc_props (.*);
